// [testbench.sv]
// self-checking bench of the transmit throttle with an application model and APB master
// assumes tt_pkg, tt_if and the design modules are compiled first
`timescale 1ns/1ns
module testbench
  import tt_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tx_req, tx_desc_has_data, tx_desc_memwr, tx_desc_addr64, tx_desc_addr2;
  logic [9:0] tx_desc_dwords;
  logic [63:0] tx_data;
  logic [63:0] link_data;
  logic tx_ack, tx_payload_valid, tx_err, tx_wait_state;
  logic prio_other = 1'b0;
  logic link_valid, link_last, link_bad;
  logic [31:0] link_lcrc;
  logic [2:0] cpl_err;
  logic [2:0] err_msg_code;
  logic cpl_pending, lp_enter, err_msg_valid, cpl_credit_infinite;
  logic lp_req = 1'b0;
  logic [6:0] cpl_err_wrap;
  logic [19:0] completion_space_report;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic prio_en = 1'b0;
  logic [2:0] prev_e = 3'h0;
  logic [2:0] got_m[$];
  logic [2:0] pl[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [2:0] em[4] = '{3'h1, 3'h2, 3'h1, 3'h2};
  logic [65:0] lw;
  logic [31:0] v;
  logic [31:0] crc_m = CRC_SEED;

  tt_core u_tt_core (
    .clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_req(tx_req), .tx_desc_has_data(tx_desc_has_data), .tx_desc_memwr(tx_desc_memwr),
    .tx_desc_addr64(tx_desc_addr64), .tx_desc_addr2(tx_desc_addr2),
    .tx_desc_dwords(tx_desc_dwords), .tx_ack(tx_ack), .tx_data(tx_data),
    .tx_payload_valid(tx_payload_valid), .tx_err(tx_err), .tx_wait_state(tx_wait_state),
    .prio_other(prio_other), .link_valid(link_valid), .link_data(link_data),
    .link_last(link_last), .link_bad(link_bad), .link_lcrc(link_lcrc), .cpl_err(cpl_err),
    .cpl_pending(cpl_pending), .lp_req(lp_req), .lp_enter(lp_enter),
    .err_msg_valid(err_msg_valid), .err_msg_code(err_msg_code), .cpl_err_wrap(cpl_err_wrap),
    .completion_space_report(completion_space_report),
    .cpl_credit_infinite(cpl_credit_infinite)
  );
  tt_app_model u_app (
    .clk(clk), .tx_ack(tx_ack), .tx_wait_state(tx_wait_state),
    .completion_space_report(completion_space_report), .tx_req(tx_req),
    .tx_desc_has_data(tx_desc_has_data), .tx_desc_memwr(tx_desc_memwr),
    .tx_desc_addr64(tx_desc_addr64), .tx_desc_addr2(tx_desc_addr2),
    .tx_desc_dwords(tx_desc_dwords), .tx_data(tx_data), .tx_payload_valid(tx_payload_valid),
    .tx_err(tx_err), .cpl_err(cpl_err), .cpl_pending(cpl_pending)
  );

  always #25 clk = ~clk;

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_link(input logic [65:0] got, input logic [65:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following transfer never re-drives psel in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk_reg(r, exp);
    chk_reg({31'h0, e}, {31'h0, ee});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk_reg({31'h0, e}, {31'h0, ee});
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  // link words, error messages and the wrapped error word against the model
  always @(posedge clk) begin
    prio_other <= prio_en && ($urandom % 4 == 0);
    prev_e <= cpl_err;
    if (srst === 1'b0 && link_valid === 1'b1) begin
      lw = u_app.exp_q.size() > 0 ? u_app.exp_q.pop_front() : {66{1'bx}};
      chk_link({link_last, link_bad, link_data}, lw);
      // running check over expected words, inverted when the packet ends bad
      crc_m = {crc_m[30:0], crc_m[31]} ^ lw[31:0] ^ lw[63:32];
      if (lw[65] === 1'b1) begin
        chk_link({34'h0, link_lcrc}, {34'h0, crc_m ^ {32{lw[64]}}});
        crc_m = CRC_SEED;
      end
    end
    if (srst === 1'b0 && err_msg_valid === 1'b1)
      got_m.push_back(err_msg_code);
    if (srst === 1'b0 && prev_e !== 3'h0)
      chk_reg({25'h0, cpl_err_wrap}, {28'h0, prev_e, 1'b0});
  end

  initial begin
    v = $urandom(78);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk_reg({31'h0, cpl_credit_infinite}, 32'h1);
    chk_reg({12'h0, completion_space_report}, 32'h40040);
    rd(ADDR_CTRL, 32'h9, 1'b0);
    rd(ADDR_STAT, 32'h0, 1'b0);
    rd(ADDR_ELOG, 32'h0, 1'b0);
    wr(8'h10, 32'hffffffff, 1'b1);
    rd(8'h10, 32'h0, 1'b1);
    rd(ADDR_CTRL, 32'h9, 1'b0);
    u_app.send(6'h20, 10'h008);
    u_app.send(6'h39, 10'h008);
    u_app.send(6'h11, 10'h006);
    u_app.send(6'h30, 10'h008);
    u_app.send(6'h26, 10'h00e);
    repeat (20) @(posedge clk);
    rd(ADDR_STAT, 32'h100, 1'b0);
    wr(ADDR_CTRL, 32'hd, 1'b0);
    prio_en <= 1'b1;
    u_app.send(6'h29, 10'h010);
    u_app.send(6'h20, 10'h001);
    prio_en <= 1'b0;
    wr(ADDR_CTRL, 32'ha, 1'b0);
    repeat (3) @(posedge clk);
    chk_reg({31'h0, tx_wait_state}, 32'h1);
    u_app.send(6'h24, 10'h006);
    wr(ADDR_CTRL, 32'h9, 1'b0);
    repeat (20) @(posedge clk);
    chk_reg({31'h0, tx_wait_state}, 32'h0);
    chk_reg(u_app.exp_q.size(), 32'h0);
    foreach (pl[i]) begin
      u_app.pulse(pl[i]);
      repeat (6) @(posedge clk);
    end
    chk_reg(got_m.size(), 32'h4);
    foreach (em[i]) chk_reg({29'h0, got_m[i]}, {29'h0, em[i]});
    rd(ADDR_ELOG, 32'h7, 1'b0);
    wr(ADDR_ELOG, 32'hf, 1'b0);
    rd(ADDR_ELOG, 32'h0, 1'b0);
    u_app.set_pending(1'b1);
    lp_req <= 1'b1;
    repeat (5) @(posedge clk);
    chk_reg({31'h0, lp_enter}, 32'h0);
    u_app.set_pending(1'b0);
    repeat (2) @(posedge clk);
    chk_reg({31'h0, lp_enter}, 32'h1);
    lp_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk_reg({31'h0, lp_enter}, 32'h0);
    v = $urandom & 32'hfffff;
    wr(ADDR_CSPC, v, 1'b0);
    rd(ADDR_CSPC, v, 1'b0);
    chk_reg({12'h0, completion_space_report}, v);
    summarize();
  end
endmodule

// [tt_app_model.sv]
// application-side model: issues descriptors with payload and pulses completion errors
// assumes the throttle core on the same clock; its tasks are called just after a rising edge
`timescale 1ns/1ns
module tt_app_model
  import tt_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic tx_ack, // descriptor accepted
  input wire logic tx_wait_state, // payload word not taken
  input wire logic [19:0] completion_space_report, // completion buffer space
  output logic tx_req, // descriptor request
  output logic tx_desc_has_data, // packet carries payload
  output logic tx_desc_memwr, // memory write
  output logic tx_desc_addr64, // 64-bit address
  output logic tx_desc_addr2, // address bit 2
  output logic [9:0] tx_desc_dwords, // payload dwords
  output logic [63:0] tx_data, // payload word
  output logic tx_payload_valid, // payload word valid
  output logic tx_err, // nullify request
  output logic [2:0] cpl_err, // completion error pulses
  output logic cpl_pending // completion outstanding
);
  // expected link words: {last, bad end, data}
  logic [65:0] exp_q[$];
  int outst = 0;

  initial begin
    tx_req = 1'b0;
    tx_desc_has_data = 1'b0;
    tx_desc_memwr = 1'b0;
    tx_desc_addr64 = 1'b0;
    tx_desc_addr2 = 1'b0;
    tx_desc_dwords = 10'h000;
    tx_data = 64'h0;
    tx_payload_valid = 1'b0;
    tx_err = 1'b0;
    cpl_err = 3'h0;
    cpl_pending = 1'b0;
  end

  // f = {write, addr64, addr2, raise error, expect bad end, keep request high}
  task automatic send(input logic [5:0] f, input logic [9:0] dw);
    int n;
    int k;
    n = f[5] ? (int'(dw) + int'(f[3]) + 1) / 2 : 0;
    k = 0;
    if (!f[5] && outst >= int'(completion_space_report[7:0])) return;
    if (!f[5]) outst++;
    tx_req <= 1'b1;
    tx_desc_has_data <= f[5];
    tx_desc_memwr <= f[5];
    tx_desc_addr64 <= f[4];
    tx_desc_addr2 <= f[3];
    tx_desc_dwords <= dw;
    tx_data <= {$urandom, $urandom};
    tx_payload_valid <= f[5];
    tx_err <= 1'b0;
    do @(posedge clk); while (tx_ack !== 1'b1);
    // a kept request is left high for the next descriptor, which follows at once
    if (!f[0]) tx_req <= 1'b0;
    while (k < n) begin
      if (tx_wait_state === 1'b0) begin
        exp_q.push_back({k == n - 1, f[1] && k == n - 1, tx_data});
        k++;
        if (k < n) begin
          tx_data <= {$urandom, $urandom};
          tx_err <= f[2];
        end
      end
      if (k < n) @(posedge clk);
    end
    // released payload lines get one idle edge before the next request
    if (!f[0]) begin
      tx_payload_valid <= 1'b0;
      tx_err <= 1'b0;
      @(posedge clk);
    end
  endtask

  // one-cycle error pulse: bit0 timeout, bit1 completer abort, bit2 unexpected
  task automatic pulse(input logic [2:0] v);
    cpl_err <= v;
    @(posedge clk);
    cpl_err <= 3'h0;
  endtask

  // completion outstanding flag
  task automatic set_pending(input logic p);
    cpl_pending <= p;
  endtask
endmodule

// [tt_core.sv]
// transmit throttle of the descriptor/data interface with completion sideband
// assumes application logic on clk and an APB master for the registers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module tt_core
  import tt_pkg::*;
(
  input wire logic clk, // core clock, 20 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic tx_req, // descriptor request
  input wire logic tx_desc_has_data, // packet carries payload
  input wire logic tx_desc_memwr, // packet is a memory write
  input wire logic tx_desc_addr64, // packet uses a 64-bit address
  input wire logic tx_desc_addr2, // address bit 2
  input wire logic [9:0] tx_desc_dwords, // payload length in dwords
  output logic tx_ack, // descriptor accepted, one cycle
  input wire logic [63:0] tx_data, // payload word
  input wire logic tx_payload_valid, // payload word valid
  input wire logic tx_err, // nullify current packet, ignored in eight-lane mode
  output logic tx_wait_state, // payload word not taken
  input wire logic prio_other, // link busy with higher priority traffic
  output logic link_valid, // word to link
  output logic [63:0] link_data, // link word
  output logic link_last, // last word of packet
  output logic link_bad, // packet ends bad
  output logic [31:0] link_lcrc, // check value at last word
  input wire logic [2:0] cpl_err, // completion error pulses
  input wire logic cpl_pending, // completion outstanding
  input wire logic lp_req, // low power requested
  output logic lp_enter, // low power state
  output logic err_msg_valid, // error message request, one cycle
  output logic [2:0] err_msg_code, // error message kind
  output logic [6:0] cpl_err_wrap, // wrapped completion error word
  output logic [19:0] completion_space_report, // completion buffer space
  output logic cpl_credit_infinite // completion credits advertised infinite
);
  tt_buf_if bif();
  tt_sb_if sif();

  tt_txbuf u_buf (
    .clk(clk),
    .srst(srst),
    .b(bif)
  );

  tt_cplsb u_sb (
    .clk(clk),
    .srst(srst),
    .s(sif)
  );

  tt_tx_e st;
  logic [1:0] lane;
  logic thr_en;
  logic gap_en;
  logic [3:0] elog;
  logic [7:0] null_cnt;
  logic [8:0] ph;
  logic [8:0] nph;
  logic hdr4;
  logic hdr4_done;
  logic err_q;
  logic gap_pend;
  logic [31:0] crc_acc;
  logic x8;
  logic can_go;
  logic do_ack;
  logic acc;
  logic last_acc;
  logic stays;
  logic [8:0] ph_n;
  logic [10:0] phases;
  logic next_ws;
  logic [31:0] crc_n;
  logic setup;
  logic wr;

  assign x8 = (lane == LANE_X8);
  assign can_go = tx_req && !tx_ack && !bif.full;
  assign do_ack = (st == TX_IDLE && can_go && !(gap_pend && gap_en)) || st == TX_GAP;
  assign acc = (st == TX_DATA) && tx_payload_valid && !tx_wait_state;
  assign last_acc = acc && (ph == nph - 9'h001);
  assign ph_n = ph + {8'h00, acc};
  assign phases = ({1'b0, tx_desc_dwords} + {10'h000, tx_desc_addr2} + 11'h001) >> 1;
  assign stays = (st == TX_DATA && !last_acc) || (do_ack && tx_desc_has_data);
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;

  assign sif.cpl_err = cpl_err;
  assign sif.cpl_pending = cpl_pending;
  assign sif.lp_req = lp_req;
  assign sif.lane_x8 = x8;
  assign lp_enter = sif.lp_enter;
  assign err_msg_valid = sif.msg_valid;
  assign err_msg_code = sif.msg_code;
  assign cpl_err_wrap = sif.err_wrap;

  // descriptor and phase tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= TX_IDLE;
      tx_ack <= 1'b0;
      gap_pend <= 1'b0;
      hdr4 <= 1'b0;
      nph <= 9'h000;
      ph <= 9'h000;
    end else begin
      tx_ack <= do_ack;
      if (do_ack) begin
        gap_pend <= tx_desc_addr64;
        hdr4 <= tx_desc_memwr && tx_desc_addr64;
        nph <= phases[8:0];
        ph <= 9'h000;
        st <= (tx_desc_has_data && phases != 11'h000) ? TX_DATA : TX_IDLE;
      end else if (st == TX_IDLE && can_go) begin
        st <= TX_GAP;
      end else begin
        ph <= ph_n;
        if (last_acc) begin
          st <= TX_IDLE;
        end
      end
    end
  end

  // wait state for the next cycle
  always_comb begin
    next_ws = x8;
    if (stays) begin
      next_ws = (bif.count >= BUF_NEAR_FULL);
      if (st == TX_DATA && prio_other) begin
        next_ws = 1'b1;
      end
      if (st == TX_DATA && hdr4 && !hdr4_done && ph_n == HDR4_WAIT_PHASE) begin
        next_ws = 1'b1;
      end
      if (thr_en && st == TX_DATA && ph_n >= THR_FREE_PHASES && !tx_wait_state) begin
        next_ws = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_wait_state <= 1'b0;
      hdr4_done <= 1'b0;
    end else begin
      tx_wait_state <= next_ws;
      if (do_ack) begin
        hdr4_done <= 1'b0;
      end else if (next_ws && hdr4 && ph_n == HDR4_WAIT_PHASE) begin
        hdr4_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      err_q <= 1'b0;
    end else if (do_ack) begin
      err_q <= 1'b0;
    end else if (st == TX_DATA && tx_err && !x8) begin
      err_q <= 1'b1;
    end
  end

  assign bif.push = acc;
  assign bif.wdata = {last_acc, !x8 && (err_q || tx_err), tx_data};
  assign bif.pop = !bif.empty && !prio_other;
  assign crc_n = {crc_acc[30:0], crc_acc[31]} ^ bif.rdata[31:0] ^ bif.rdata[63:32];

  // link side: words leave with a running check, inverted on a bad end
  always_ff @(posedge clk) begin
    if (srst) begin
      link_valid <= 1'b0;
      link_data <= 64'h0;
      link_last <= 1'b0;
      link_bad <= 1'b0;
      link_lcrc <= 32'h0;
      crc_acc <= CRC_SEED;
      null_cnt <= 8'h00;
    end else begin
      link_valid <= bif.pop;
      link_last <= bif.pop && bif.rdata[ENT_W-1];
      link_bad <= bif.pop && bif.rdata[ENT_W-1] && bif.rdata[WORD_W];
      if (bif.pop) begin
        link_data <= bif.rdata[WORD_W-1:0];
        crc_acc <= bif.rdata[ENT_W-1] ? CRC_SEED : crc_n;
        if (bif.rdata[ENT_W-1]) begin
          link_lcrc <= crc_n ^ {32{bif.rdata[WORD_W]}};
          null_cnt <= null_cnt + {7'h00, bif.rdata[WORD_W]};
        end
      end
    end
  end

  // apb slave: one wait-free access phase, read data captured in setup
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= 1'b0;
        if (paddr == ADDR_CTRL) begin
          prdata <= {28'h0, gap_en, thr_en, lane};
        end else if (paddr == ADDR_STAT) begin
          prdata <= {16'h0, null_cnt, 4'h0, bif.full, tx_wait_state, lp_enter,
            st != TX_IDLE};
        end else if (paddr == ADDR_CSPC) begin
          prdata <= {12'h0, completion_space_report};
        end else if (paddr == ADDR_ELOG) begin
          prdata <= {28'h0, elog};
        end else begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lane <= CTRL_LANE_RST;
      thr_en <= 1'b0;
      gap_en <= 1'b1;
      completion_space_report <= {CSPC_DATA_RST, CSPC_HDR_RST};
    end else if (wr && paddr == ADDR_CTRL) begin
      lane <= pwdata[1:0];
      thr_en <= pwdata[CTRL_THR_BIT];
      gap_en <= pwdata[CTRL_GAP_BIT];
    end else if (wr && paddr == ADDR_CSPC) begin
      completion_space_report <= pwdata[19:0];
    end
  end

  // error log bits clear on writing one; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      elog <= 4'h0;
    end else begin
      elog <= (elog & ~((wr && paddr == ADDR_ELOG) ? pwdata[3:0] : 4'h0)) |
        {sif.lp_deferred, cpl_err};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cpl_credit_infinite <= 1'b1;
    end else begin
      cpl_credit_infinite <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_HDR4_WAIT: assert property (st == TX_DATA && hdr4 && !hdr4_done && acc &&
    ph == 9'h001 && !last_acc |=> tx_wait_state)
    else $error("no wait in third phase of four-dword header write");
  AST_NO_OVERFLOW: assert property (bif.push |-> !bif.full)
    else $error("payload word pushed into full buffer");
  AST_PRIO_WAIT: assert property (st == TX_DATA && prio_other && !last_acc
    |=> tx_wait_state)
    else $error("no wait while priority is elsewhere");
  AST_X8_NO_NULL: assert property (x8 && st == TX_DATA |-> !bif.push ||
    !bif.wdata[WORD_W] || err_q)
    else $error("eight-lane mode used transmit error");
  AST_GAP_SLIP: assert property (st == TX_IDLE && can_go && gap_pend && gap_en
    |=> !tx_ack ##1 tx_ack)
    else $error("acknowledge after 64-bit packet did not slip one cycle");
  AST_THROTTLE: assert property (thr_en && st == TX_DATA && acc && ph >= 9'h001 &&
    !last_acc |=> tx_wait_state)
    else $error("throttle did not insert a wait");
  AST_NULLIFY: assert property (bif.pop && bif.rdata[ENT_W-1] && bif.rdata[WORD_W]
    |=> link_bad && link_last && link_lcrc == ~$past(crc_n))
    else $error("nullified packet not ended bad");
  AST_CSPC_STATIC: assert property (!(wr && paddr == ADDR_CSPC)
    |=> $stable(completion_space_report))
    else $error("completion space changed without a write");
  AST_INF_CRED: assert property (cpl_credit_infinite)
    else $error("completion credits not infinite");
  AST_IDLE_WAIT: assert property (st == TX_IDLE && !do_ack
    |=> tx_wait_state == ($past(lane) == LANE_X8))
    else $error("idle wait level wrong for lane mode");
  COV_BACK_TO_BACK: cover property (tx_ack ##[1:20] tx_ack && tx_req);
  COV_NULLIFIED: cover property (link_bad);
  COV_HDR4: cover property (hdr4 && tx_wait_state && st == TX_DATA);
  COV_GAP: cover property (st == TX_GAP);
endmodule

// [tt_cplsb.sv]
// completion sideband: error pulses to messages, wrapped error word, low-power gate
// assumes error pulses arrive from logic on the same clock
`timescale 1ns/1ns
module tt_cplsb
  import tt_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic srst, // synchronous reset, active high
  tt_sb_if.side s // sideband signals
);
  logic [MSG_BITS-1:0] pend;
  logic [MSG_BITS-1:0] sent;

  assign sent[0] = pend[0];
  assign sent[1] = pend[1] && !pend[0];

  // a new pulse in the cycle its message leaves is kept pending
  genvar i;
  generate
    for (i = 0; i < MSG_BITS; i++) begin : g_pend
      always_ff @(posedge clk) begin
        if (srst) begin
          pend[i] <= 1'b0;
        end else begin
          pend[i] <= (pend[i] && !sent[i]) || s.cpl_err[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      s.msg_valid <= 1'b0;
      s.msg_code <= 3'h0;
    end else begin
      s.msg_valid <= |pend;
      s.msg_code <= pend[0] ? MSG_TIMEOUT : (pend[1] ? MSG_ABORT : 3'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s.err_wrap <= 7'h00;
    end else begin
      s.err_wrap <= s.lane_x8 ? 7'h00 : {3'h0, s.cpl_err, 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s.lp_enter <= 1'b0;
      s.lp_deferred <= 1'b0;
    end else begin
      if (!s.lp_req) begin
        s.lp_enter <= 1'b0;
      end else if (!s.cpl_pending) begin
        s.lp_enter <= 1'b1;
      end
      s.lp_deferred <= s.lp_req && s.cpl_pending && !s.lp_enter;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_WRAP_FORMAT: assert property (!s.lane_x8 |=>
    s.err_wrap == {3'h0, $past(s.cpl_err), 1'b0})
    else $error("wrapped completion error word malformed");
  AST_LP_DEFER: assert property ($rose(s.lp_enter) |-> !$past(s.cpl_pending))
    else $error("low power entered while completion pending");
  AST_TIMEOUT_MSG: assert property (s.cpl_err[0] |-> ##2 s.msg_valid &&
    s.msg_code == MSG_TIMEOUT)
    else $error("timeout pulse gave no error message");
  COV_LP_DEFER: cover property (s.lp_deferred ##[1:20] $rose(s.lp_enter));
endmodule

// [tt_if.sv]
// carriers between the throttle core, its word buffer and its completion sideband
// assumes tt_pkg is compiled first
`timescale 1ns/1ns
interface tt_buf_if;
  import tt_pkg::*;
  logic push;
  logic pop;
  logic [ENT_W-1:0] wdata;
  logic [ENT_W-1:0] rdata;
  logic [1:0] count;
  logic full;
  logic empty;
  modport core(output push, pop, wdata, input rdata, count, full, empty);
  modport store(input push, pop, wdata, output rdata, count, full, empty);
endinterface

interface tt_sb_if;
  logic [2:0] cpl_err;
  logic cpl_pending;
  logic lp_req;
  logic lane_x8;
  logic msg_valid;
  logic [2:0] msg_code;
  logic [6:0] err_wrap;
  logic lp_enter;
  logic lp_deferred;
  modport core(output cpl_err, cpl_pending, lp_req, lane_x8,
    input msg_valid, msg_code, err_wrap, lp_enter, lp_deferred);
  modport side(input cpl_err, cpl_pending, lp_req, lane_x8,
    output msg_valid, msg_code, err_wrap, lp_enter, lp_deferred);
endinterface

// [tt_pkg.sv]
// constants, register map and state types of the transmit throttle block
// assumes nothing beyond a SystemVerilog compiler
package tt_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CSPC = 8'h08;
  localparam logic [7:0] ADDR_ELOG = 8'h0c;
  localparam logic [1:0] LANE_X1 = 2'h0;
  localparam logic [1:0] LANE_X4 = 2'h1;
  localparam logic [1:0] LANE_X8 = 2'h2;
  localparam int CTRL_THR_BIT = 2;
  localparam int CTRL_GAP_BIT = 3;
  localparam logic [1:0] CTRL_LANE_RST = LANE_X4;
  localparam logic [7:0] CSPC_HDR_RST = 8'h40;
  localparam logic [11:0] CSPC_DATA_RST = 12'h400;
  localparam int WORD_W = 64;
  localparam int ENT_W = WORD_W + 2;
  localparam logic [1:0] BUF_DEPTH = 2'h3;
  localparam logic [1:0] BUF_NEAR_FULL = 2'h2;
  localparam logic [8:0] HDR4_WAIT_PHASE = 9'h002;
  localparam logic [8:0] THR_FREE_PHASES = 9'h002;
  localparam logic [31:0] CRC_SEED = 32'hffffffff;
  localparam int MSG_BITS = 2;
  localparam logic [2:0] MSG_TIMEOUT = 3'h1;
  localparam logic [2:0] MSG_ABORT = 3'h2;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_GAP = 2'b01,
    TX_DATA = 2'b10
  } tt_tx_e;
endpackage

// [tt_txbuf.sv]
// three-entry show-ahead word buffer of the transmit path
// assumes the writer never pushes while full and the reader never pops while empty
`timescale 1ns/1ns
module tt_txbuf
  import tt_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic srst, // synchronous reset, active high
  tt_buf_if.store b // push and pop side
);
  logic [ENT_W-1:0] mem [0:2];
  logic [1:0] wp;
  logic [1:0] rp;
  logic do_push;
  logic do_pop;

  assign do_push = b.push && !b.full;
  assign do_pop = b.pop && !b.empty;
  assign b.full = (b.count == BUF_DEPTH);
  assign b.empty = (b.count == 2'h0);
  assign b.rdata = mem[rp];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= b.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp <= 2'h0;
      rp <= 2'h0;
      b.count <= 2'h0;
    end else begin
      if (do_push) begin
        wp <= (wp == BUF_DEPTH - 2'h1) ? 2'h0 : wp + 2'h1;
      end
      if (do_pop) begin
        rp <= (rp == BUF_DEPTH - 2'h1) ? 2'h0 : rp + 2'h1;
      end
      b.count <= b.count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end
endmodule
